// ### common/usbk_map.vh
// usbk_map.vh: register offsets, field positions and reset values of the serial port
// assumes: included by the port's design files, 32-bit apb data, one register per aligned word
`ifndef USBK_MAP_VH
`define USBK_MAP_VH

// register byte offsets
`define USBK_OFS_BAUD_CONTROL 8'h00
`define USBK_OFS_RX_STATUS_CONTROL 8'h04
`define USBK_OFS_DIVIDER_LOW 8'h08
`define USBK_OFS_DIVIDER_HIGH 8'h0C
`define USBK_OFS_TX_HOLDING 8'h10
`define USBK_OFS_TX_STATUS_CONTROL 8'h14
`define USBK_OFS_RX_DATA 8'h18
`define USBK_OFS_EVENT_FLAGS 8'h1C

// baud_control fields
`define USBK_BC_RX_IDLE 6
`define USBK_BC_DATA_INVERT 5
`define USBK_BC_CLOCK_IDLE 4
`define USBK_BC_WIDE_DIV 3
`define USBK_BC_WAKE_BREAK 1
`define USBK_BC_AUTO_BAUD 0
`define USBK_BC_WMASK 8'h3B

// receive_status_control fields
`define USBK_RS_PORT_EN 7
`define USBK_RS_RX9 6
`define USBK_RS_SINGLE_RX 5
`define USBK_RS_CONT_RX 4
`define USBK_RS_FRAMING 2
`define USBK_RS_WMASK 8'hF8

// transmit_status_control fields
`define USBK_TS_MASTER 7
`define USBK_TS_NINE_BIT 6
`define USBK_TS_TX_EN 5
`define USBK_TS_SYNC 4
`define USBK_TS_HIGH_SPEED 2
`define USBK_TS_SHIFT_EMPTY 1
`define USBK_TS_NINTH_BIT 0
`define USBK_TS_WMASK 8'hF5

// event_flags fields
`define USBK_EV_TX_EMPTY 0
`define USBK_EV_RX_DONE 1
`define USBK_EV_BREAK 2

// reset value and break data byte
`define USBK_RST_REG8 8'h00
`define USBK_BREAK_DATA 8'h00

// last quarter-tick index of a bit (four ticks per bit) and data bits per character
`define USBK_QTICKS_PER_BIT 2'h3
`define USBK_DATA_BITS 4'h8

`endif

// ### core/usbk_baud.v
// usbk_baud.v: baud rate generator, one-cycle pulse per quarter bit time
// assumes: divider and speed selects come from registers on the same clock
`timescale 1ns/1ps
`include "usbk_map.vh"

module usbk_baud (
  input wire sys_clk,
  input wire rstn,
  input wire run,
  input wire wide_divider_select,
  input wire high_speed_baud_select,
  input wire [15:0] divider,
  output reg qtick
);
  reg [20:0] cnt_reg;
  reg [20:0] scale;
  wire [20:0] n_ext;
  wire [20:0] span;

  // quarter of the 64/16/16/4 prescale
  always @* begin
    case ({wide_divider_select, high_speed_baud_select})
      2'b00: scale = 21'h000010;
      2'b11: scale = 21'h000001;
      default: scale = 21'h000004;
    endcase
  end

  // narrow mode ignores the high byte
  assign n_ext = {5'h00, (wide_divider_select ? divider : {8'h00, divider[7:0]})};
  assign span = (n_ext + 21'h000001) * scale - 21'h000001;

  // restart from zero while stopped so the first tick is a whole period away
  always @(posedge sys_clk) begin
    if (!rstn || !run) begin
      cnt_reg <= 21'h000000;
      qtick <= 1'b0;
    end else if (cnt_reg >= span) begin
      cnt_reg <= 21'h000000;
      qtick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 21'h000001;
      qtick <= 1'b0;
    end
  end
endmodule // usbk_baud

// ### core/usbk_rx.v
// usbk_rx.v: asynchronous receiver with framing check and wake-on-break watcher
// assumes: line is already synchronised and polarity-corrected; qtick is a quarter bit
`timescale 1ns/1ps
`include "usbk_map.vh"

module usbk_rx (
  input wire sys_clk,
  input wire rstn,
  input wire enable,
  input wire qtick,
  input wire line,
  input wire wake_armed,
  output reg byte_valid,
  output reg [7:0] byte_data,
  output reg framing_error,
  output wire rx_idle,
  output reg wake_event,
  output reg wake_done
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_STOP = 4'b1000;

  reg [3:0] state_reg;
  reg [1:0] q_reg;
  reg [2:0] bit_reg;
  reg [7:0] shift_reg;
  reg line_prev_reg;
  reg wake_fell_reg;

  assign rx_idle = state_reg[0];

  // start at line fall, sample mid start bit, then each bit centre
  always @(posedge sys_clk) begin
    if (!rstn || !enable) begin
      state_reg <= ST_IDLE;
      q_reg <= 2'h0;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      line_prev_reg <= 1'b1;
      wake_fell_reg <= 1'b0;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      framing_error <= 1'b0;
      wake_event <= 1'b0;
      wake_done <= 1'b0;
    end else begin
      line_prev_reg <= line;
      byte_valid <= 1'b0;
      wake_event <= 1'b0;
      wake_done <= 1'b0;
      if (wake_armed) begin
        // normal reception held off; first fall wakes, next rise ends the break
        state_reg <= ST_IDLE;
        if (line_prev_reg && !line && !wake_fell_reg) begin
          wake_fell_reg <= 1'b1;
          wake_event <= 1'b1;
        end else if (!line_prev_reg && line && wake_fell_reg) begin
          wake_fell_reg <= 1'b0;
          wake_done <= 1'b1;
        end
      end else begin
        wake_fell_reg <= 1'b0;
        case (state_reg)
          ST_IDLE: begin
            q_reg <= 2'h0;
            if (line_prev_reg && !line) begin
              state_reg <= ST_START;
            end
          end
          ST_START: begin
            if (qtick) begin
              q_reg <= q_reg + 2'h1;
              if (q_reg == 2'h1) begin
                q_reg <= 2'h0;
                bit_reg <= 3'h0;
                state_reg <= line ? ST_IDLE : ST_DATA; // glitch rejected
              end
            end
          end
          ST_DATA: begin
            if (qtick) begin
              q_reg <= q_reg + 2'h1;
              if (q_reg == `USBK_QTICKS_PER_BIT) begin
                shift_reg <= {line, shift_reg[7:1]};
                bit_reg <= bit_reg + 3'h1;
                if (bit_reg == 3'h7) begin
                  state_reg <= ST_STOP;
                end
              end
            end
          end
          ST_STOP: begin
            if (qtick) begin
              q_reg <= q_reg + 2'h1;
              if (q_reg == `USBK_QTICKS_PER_BIT) begin
                byte_valid <= 1'b1;
                byte_data <= shift_reg;
                framing_error <= !line; // low stop bit, as a break gives
                state_reg <= ST_IDLE;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // usbk_rx

// ### core/usbk_top.v
// usbk_top.v: serial port with break reception and synchronous master transmit, apb slave
// assumes: apb master on sys_clk; data pin comes from outside and is synchronised here
//
// Overview of operation
// - received byte 00h with framing error and receive-complete flag signals a break
// - wake-on-break: watch two line transitions, interrupt, then receive next byte
// - wake-on-break enable clears itself when the line rises after the break
// - synchronous mode: one data line, one clock line, half-duplex only
// - synchronous characters carry only data bits, no start or stop bits
// - master needs mode, clock source, port enable set; receive enables pick direction
// - master drives the shift clock and enables the clock pin driver when configured
// - data changes on the leading clock edge, is sampled on the trailing edge; here data changes one cycle before the leading edge
// - exactly one clock cycle per data bit, no extra clocks
// - polarity bit set: clock idles high; cleared: clock idles low
// - master transmit shifts data out and enables data and clock pin drivers
// - holding register write starts sending; waits while shift register is busy
// - empty shift register takes the character at once and starts shifting
// - data invert defaults to 0; 1 makes transmit and receive data low-true
// - transmit shift register is not visible to software
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "usbk_map.vh"

module usbk_top (
  input wire sys_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire data_pin_in,
  output reg data_pin_out,
  output wire data_pin_oe,
  output reg clock_pin_out,
  output wire clock_pin_oe
);
  localparam TX_IDLE = 2'b01;
  localparam TX_SHIFT = 2'b10;

  // software-visible registers
  reg [7:0] baud_control_reg;
  reg [7:0] receive_status_control_reg;
  reg [7:0] baud_divider_low_reg;
  reg [7:0] baud_divider_high_reg;
  reg [7:0] transmit_status_control_reg;
  reg [8:0] transmit_holding_register;
  reg hold_full_reg;
  reg receive_complete_flag;
  reg framing_error_flag;
  reg [7:0] receive_data_register;

  // transmit engine, not reachable from the bus
  reg [1:0] tx_state_reg;
  reg [8:0] transmit_shift_register;
  reg [3:0] bits_left_reg;
  reg [1:0] phase_reg;

  // data pin synchroniser
  reg data_meta_reg;
  reg data_sync_reg;

  wire port_enable = receive_status_control_reg[`USBK_RS_PORT_EN];
  wire single_receive_enable = receive_status_control_reg[`USBK_RS_SINGLE_RX];
  wire continuous_receive_enable = receive_status_control_reg[`USBK_RS_CONT_RX];
  wire clock_source_master = transmit_status_control_reg[`USBK_TS_MASTER];
  wire nine_bit_transmit_enable = transmit_status_control_reg[`USBK_TS_NINE_BIT];
  wire transmit_enable = transmit_status_control_reg[`USBK_TS_TX_EN];
  wire sync_mode = transmit_status_control_reg[`USBK_TS_SYNC];
  wire transmit_ninth_bit = transmit_status_control_reg[`USBK_TS_NINTH_BIT];
  wire data_invert = baud_control_reg[`USBK_BC_DATA_INVERT];
  wire clock_idle_polarity = baud_control_reg[`USBK_BC_CLOCK_IDLE];
  wire wake_on_break_enable = baud_control_reg[`USBK_BC_WAKE_BREAK];

  // master configured at all, and master transmit direction
  wire sync_master = port_enable && sync_mode && clock_source_master;
  wire receive_selected = single_receive_enable || continuous_receive_enable;
  wire sync_tx_mode = sync_master && !receive_selected && transmit_enable;

  wire shift_register_empty = tx_state_reg[0];
  wire transmit_buffer_empty_flag = !hold_full_reg;
  wire break_received;

  wire qtick;
  wire rx_valid;
  wire [7:0] rx_byte;
  wire rx_framing;
  wire rx_idle;
  wire wake_event;
  wire wake_done;
  wire rx_line;

  // apb decode
  wire apb_setup = psel && !penable;
  wire apb_access = psel && penable;
  wire wr_en = apb_access && pwrite;
  wire rd_en = apb_access && !pwrite;

  function addr_known;
    input [7:0] a;
    begin
      addr_known = (a[1:0] == 2'b00) && (a <= `USBK_OFS_EVENT_FLAGS);
    end
  endfunction

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // zero-wait slave; unmapped or misaligned offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_known(paddr);

  // both pin drivers follow configuration, not software direction bits
  assign clock_pin_oe = sync_master;
  assign data_pin_oe = sync_tx_mode;

  // break: all three conditions at once
  assign break_received = receive_complete_flag && framing_error_flag &&
                          (receive_data_register == `USBK_BREAK_DATA);

  // receive line is inverted back before any decoding
  assign rx_line = data_sync_reg ^ data_invert;

  // two flops before the pin reaches logic
  always @(posedge sys_clk) begin
    if (!rstn) begin
      data_meta_reg <= 1'b1;
      data_sync_reg <= 1'b1;
    end else begin
      data_meta_reg <= data_pin_in;
      data_sync_reg <= data_meta_reg;
    end
  end

  usbk_baud u_baud (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(port_enable),
    .wide_divider_select(baud_control_reg[`USBK_BC_WIDE_DIV]),
    .high_speed_baud_select(transmit_status_control_reg[`USBK_TS_HIGH_SPEED]),
    .divider({baud_divider_high_reg, baud_divider_low_reg}),
    .qtick(qtick)
  );

  // asynchronous receiver only runs outside synchronous mode
  usbk_rx u_rx (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .enable(port_enable && !sync_mode),
    .qtick(qtick),
    .line(rx_line),
    .wake_armed(wake_on_break_enable),
    .byte_valid(rx_valid),
    .byte_data(rx_byte),
    .framing_error(rx_framing),
    .rx_idle(rx_idle),
    .wake_event(wake_event),
    .wake_done(wake_done)
  );

  // register writes; clearing port enable resets the port state below
  always @(posedge sys_clk) begin
    if (!rstn) begin
      baud_control_reg <= `USBK_RST_REG8;
      receive_status_control_reg <= `USBK_RST_REG8;
      baud_divider_low_reg <= `USBK_RST_REG8;
      baud_divider_high_reg <= `USBK_RST_REG8;
      transmit_status_control_reg <= `USBK_RST_REG8; // data invert starts at 0
    end else begin
      if (wr_en && hit(paddr, `USBK_OFS_BAUD_CONTROL)) begin
        baud_control_reg <= pwdata[7:0] & `USBK_BC_WMASK;
      end else if (wake_done) begin
        baud_control_reg[`USBK_BC_WAKE_BREAK] <= 1'b0;
      end
      if (wr_en && hit(paddr, `USBK_OFS_RX_STATUS_CONTROL)) begin
        receive_status_control_reg <= pwdata[7:0] & `USBK_RS_WMASK;
      end
      if (wr_en && hit(paddr, `USBK_OFS_DIVIDER_LOW)) begin
        baud_divider_low_reg <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, `USBK_OFS_DIVIDER_HIGH)) begin
        baud_divider_high_reg <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, `USBK_OFS_TX_STATUS_CONTROL)) begin
        transmit_status_control_reg <= pwdata[7:0] & `USBK_TS_WMASK;
      end
    end
  end

  // receive flag: hardware set wins over the clearing read
  always @(posedge sys_clk) begin
    if (!rstn || !port_enable) begin
      receive_complete_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      receive_data_register <= 8'h00;
    end else if (rx_valid) begin
      receive_complete_flag <= 1'b1;
      framing_error_flag <= rx_framing;
      receive_data_register <= rx_byte;
    end else if (wake_event) begin
      receive_complete_flag <= 1'b1; // wake raises its own receive event
    end else if (rd_en && hit(paddr, `USBK_OFS_RX_DATA)) begin
      receive_complete_flag <= 1'b0;
    end
  end

  // holding register: a write queues a character, the engine takes it
  always @(posedge sys_clk) begin
    if (!rstn || !port_enable) begin
      transmit_holding_register <= 9'h000;
      hold_full_reg <= 1'b0;
    end else if (wr_en && hit(paddr, `USBK_OFS_TX_HOLDING)) begin
      // ninth bit is captured now, so it must be loaded first
      transmit_holding_register <= {transmit_ninth_bit, pwdata[7:0]};
      hold_full_reg <= 1'b1;
    end else if (sync_tx_mode && tx_state_reg == TX_IDLE && hold_full_reg) begin
      hold_full_reg <= 1'b0; // moved to the shifter
    end
  end

  // transmit engine: four quarter ticks per bit, leading edge at the first,
  // trailing edge at the third; no start or stop framing
  always @(posedge sys_clk) begin
    if (!rstn || !sync_tx_mode) begin
      tx_state_reg <= TX_IDLE;
      transmit_shift_register <= 9'h000;
      bits_left_reg <= 4'h0;
      phase_reg <= 2'h0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          phase_reg <= 2'h0;
          if (hold_full_reg) begin
            transmit_shift_register <= transmit_holding_register;
            bits_left_reg <= `USBK_DATA_BITS + {3'h0, nine_bit_transmit_enable};
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (qtick) begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == `USBK_QTICKS_PER_BIT) begin
              transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
              bits_left_reg <= bits_left_reg - 4'h1;
              if (bits_left_reg == 4'h1) begin
                // last bit gone; a waiting character loads next cycle
                tx_state_reg <= TX_IDLE;
              end
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // pin drive: clock leaves idle at phase 1 and returns at phase 3
  always @(posedge sys_clk) begin
    if (!rstn) begin
      clock_pin_out <= 1'b0;
      data_pin_out <= 1'b0;
    end else begin
      if (tx_state_reg == TX_SHIFT && (phase_reg == 2'h1 || phase_reg == 2'h2)) begin
        clock_pin_out <= !clock_idle_polarity; // one pulse per bit
      end else begin
        clock_pin_out <= clock_idle_polarity; // rests at idle level
      end
      // new bit appears one cycle before the leading edge and holds to the next
      if (tx_state_reg == TX_SHIFT && qtick && phase_reg == 2'h0) begin
        data_pin_out <= transmit_shift_register[0] ^ data_invert;
      end
    end
  end

  // read data registered in the setup phase, valid through the access phase
  always @(posedge sys_clk) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup && !pwrite) begin
      case (paddr)
        `USBK_OFS_BAUD_CONTROL:
          prdata <= {24'h000000, baud_control_reg[7], rx_idle, baud_control_reg[5:0]};
        `USBK_OFS_RX_STATUS_CONTROL:
          prdata <= {24'h000000, receive_status_control_reg[7:3], framing_error_flag, 2'b00};
        `USBK_OFS_DIVIDER_LOW:
          prdata <= {24'h000000, baud_divider_low_reg};
        `USBK_OFS_DIVIDER_HIGH:
          prdata <= {24'h000000, baud_divider_high_reg};
        `USBK_OFS_TX_STATUS_CONTROL:
          prdata <= {24'h000000, transmit_status_control_reg[7:2], shift_register_empty,
                     transmit_status_control_reg[0]};
        `USBK_OFS_RX_DATA:
          prdata <= {24'h000000, receive_data_register};
        `USBK_OFS_EVENT_FLAGS:
          prdata <= {29'h00000000, break_received, receive_complete_flag, transmit_buffer_empty_flag};
        default:
          prdata <= 32'h00000000; // holding register is write-only
      endcase
    end
  end
endmodule // usbk_top

// ### verification/tb_usart_sync_master_tx_break_rx.sv
// tb_usart_sync_master_tx_break_rx.sv: apb-driven bench for sync transmit and break reception
// assumes: usbk_top with zero-wait apb; undriven data line is pulled high
`timescale 1ns/1ps
`include "usbk_map.vh"
module tb_usart_sync_master_tx_break_rx;
  reg sys_clk, rstn, psel, penable, pwrite, line_drv, clear, idle_high, err;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, data_pin_out, data_pin_oe, clock_pin_out, clock_pin_oe;
  wire [15:0] sh;
  wire [7:0] bits;
  wire data_wire = data_pin_oe ? data_pin_out : line_drv; // digital pads only, no analog use to turn off
  integer miscompares, compares, i, j, k, t;

  usbk_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_pin_in(data_wire),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .clock_pin_out(clock_pin_out),
    .clock_pin_oe(clock_pin_oe));
  usbk_slave_model i_slave (.sck(clock_pin_out), .sdata(data_wire), .idle_high(idle_high), .clear(clear),
    .shift_reg(sh), .bit_cnt(bits));

  // 125 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task complete_run;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask

  task chk(input [95:0] what, input [31:0] exp, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected %0s: expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // one apb transfer; an edge always passes before psel rises again
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      t = 0;
      do begin
        @(posedge sys_clk);
        t = t + 1;
      end while (pready !== 1'b1 && t < 50);
      if (t >= 50) begin
        miscompares = miscompares + 1;
        complete_run;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task ticks(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask

  // bounded wait for the slave to count n samples
  task wait_bits(input [7:0] n);
    begin
      t = 0;
      while (bits < n && t < 3000) begin
        @(posedge sys_clk);
        t = t + 1;
      end
      if (t >= 3000) begin
        miscompares = miscompares + 1;
        complete_run;
      end
    end
  endtask

  // async frame on the line, 16 cycles a bit: divider 3 with wide and high-speed selects
  task send(input [9:0] frame);
    for (j = 0; j < 10; j = j + 1) begin
      line_drv <= frame[j];
      ticks(16);
    end
  endtask

  initial begin
    miscompares = 0;
    compares = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    line_drv = 1'b1;
    clear = 1'b1;
    idle_high = 1'b0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    // reset values, rx_idle masked; holes answer with an error
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset", (i == 5) ? 32'h02 : (i == 7) ? 32'h01 : 32'h00, rd & ((i == 0) ? 32'hBF : 32'hFF));
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("hole err", 32'h1, err);
    chk("hole data", 32'h0, rd);
    apb(1'b1, 8'h22, 32'hFF);
    chk("misalign", 32'h1, err);
    $display("registers test done");
    // sync transmit over both idle levels and both data senses
    apb(1'b1, `USBK_OFS_DIVIDER_LOW, 32'h01);
    apb(1'b1, `USBK_OFS_DIVIDER_HIGH, 32'h00);
    for (k = 0; k < 4; k = k + 1) begin
      clear <= 1'b1;
      apb(1'b1, `USBK_OFS_TX_STATUS_CONTROL, 32'h00);
      apb(1'b1, `USBK_OFS_BAUD_CONTROL, {26'h0, k[1], k[0], 4'h8});
      apb(1'b1, `USBK_OFS_RX_STATUS_CONTROL, 32'h80);
      apb(1'b1, `USBK_OFS_TX_STATUS_CONTROL, 32'hB4);
      idle_high <= k[0];
      ticks(4);
      clear <= 1'b0;
      chk("idle clk", k[0], clock_pin_out);
      chk("drivers", 32'h3, {data_pin_oe, clock_pin_oe});
      apb(1'b1, `USBK_OFS_TX_HOLDING, 32'hA5);
      apb(1'b1, `USBK_OFS_TX_HOLDING, 32'h3C);
      apb(1'b0, `USBK_OFS_EVENT_FLAGS, 32'h0);
      chk("tx full", 32'h0, rd[0]);
      wait_bits(8'd16);
      ticks(40);
      chk("clocks", 32'd16, bits);
      chk("tx data", k[1] ? 32'hC35A : 32'h3CA5, sh);
      chk("idle clk", k[0], clock_pin_out);
      apb(1'b0, `USBK_OFS_TX_STATUS_CONTROL, 32'h0);
      chk("shift empty", 32'h1, rd[1]);
      $display("sync transmit test %0d done", k);
    end
    // nine bits, ninth loaded before the low byte, data still inverted
    clear <= 1'b1;
    apb(1'b1, `USBK_OFS_TX_STATUS_CONTROL, 32'hF5);
    clear <= 1'b0;
    apb(1'b1, `USBK_OFS_TX_HOLDING, 32'h5A);
    wait_bits(8'd9);
    ticks(40);
    chk("clocks9", 32'd9, bits);
    chk("tx data9", 32'h0A5, sh[15:7]);
    // a receive enable turns the data driver off and blocks sending
    apb(1'b1, `USBK_OFS_RX_STATUS_CONTROL, 32'h90);
    clear <= 1'b1;
    // the enable write lands on the edge the task returns at; let it settle
    ticks(2);
    chk("rx drivers", 32'h1, {data_pin_oe, clock_pin_oe});
    clear <= 1'b0;
    apb(1'b1, `USBK_OFS_TX_HOLDING, 32'hFF);
    ticks(100);
    chk("no clocks", 32'h0, bits);
    $display("sync options test done");
    // async break by framing error with zero data
    apb(1'b1, `USBK_OFS_RX_STATUS_CONTROL, 32'h00);
    // high-speed select keeps the quarter bit at 4 cycles, so a bit is 16
    apb(1'b1, `USBK_OFS_TX_STATUS_CONTROL, 32'h04);
    apb(1'b1, `USBK_OFS_BAUD_CONTROL, 32'h08);
    apb(1'b1, `USBK_OFS_DIVIDER_LOW, 32'h03);
    apb(1'b1, `USBK_OFS_RX_STATUS_CONTROL, 32'h80);
    ticks(20);
    send(10'h000);
    line_drv <= 1'b1;
    ticks(40);
    apb(1'b0, `USBK_OFS_RX_STATUS_CONTROL, 32'h0);
    chk("framing", 32'h1, rd[2]);
    apb(1'b0, `USBK_OFS_EVENT_FLAGS, 32'h0);
    chk("break", 32'h3, rd[2:1]);
    apb(1'b0, `USBK_OFS_RX_DATA, 32'h0);
    chk("break data", 32'h00, rd);
    apb(1'b0, `USBK_OFS_EVENT_FLAGS, 32'h0);
    chk("rx cleared", 32'h0, rd[1]);
    // wake on break with auto-baud armed too: fall flags, rise disarms, next byte received normally
    apb(1'b1, `USBK_OFS_BAUD_CONTROL, 32'h0B);
    ticks(4);
    line_drv <= 1'b0;
    ticks(30);
    apb(1'b0, `USBK_OFS_EVENT_FLAGS, 32'h0);
    chk("wake flag", 32'h1, rd[1]);
    apb(1'b0, `USBK_OFS_BAUD_CONTROL, 32'h0);
    chk("wake armed", 32'h1, rd[1]);
    line_drv <= 1'b1;
    ticks(20);
    apb(1'b0, `USBK_OFS_BAUD_CONTROL, 32'h0);
    chk("wake clear", 32'h0, rd[1]);
    apb(1'b0, `USBK_OFS_RX_DATA, 32'h0);
    send({1'b1, 8'h55, 1'b0});
    ticks(40);
    apb(1'b0, `USBK_OFS_EVENT_FLAGS, 32'h0);
    chk("next byte", 32'h1, rd[1]);
    apb(1'b0, `USBK_OFS_RX_DATA, 32'h0);
    chk("next data", 32'h55, rd);
    $display("break receive test done");
    complete_run;
  end
endmodule // tb_usart_sync_master_tx_break_rx

// ### verification/usbk_checker.sv
// usbk_checker.sv: port-level assertions for the serial port top
// assumes: bound into usbk_top, one sys_clk domain, rstn synchronous active low
`timescale 1ns/1ps
module usbk_checker (
  input wire sys_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire data_pin_out,
  input wire data_pin_oe,
  input wire clock_pin_out,
  input wire clock_pin_oe
);
  // bus answers: zero wait, errors only for holes in the map
  a_ready_always: assert property (@(posedge sys_clk) disable iff (!rstn) pready) else $error("pready low");
  a_bad_addr_err: assert property (@(posedge sys_clk) disable iff (!rstn)
    psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h1C) |-> pslverr) else $error("no error on hole");
  a_err_in_access: assert property (@(posedge sys_clk) disable iff (!rstn)
    pslverr |-> psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h1C)) else $error("stray error");
  a_rdata_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("read data moved");
  // no reset check of its own: reset must leave the pins released
  a_reset_quiet: assert property (@(posedge sys_clk)
    !$past(rstn) |-> !data_pin_oe && !clock_pin_oe && prdata == 32'h0) else $error("pins driven after reset");
  // link: data driver implies clock driver, data leads the clock edge
  a_oe_pair: assert property (@(posedge sys_clk) disable iff (!rstn)
    data_pin_oe |-> clock_pin_oe) else $error("data driven without clock");
  a_data_leads: assert property (@(posedge sys_clk) disable iff (!rstn)
    $changed(data_pin_out) && data_pin_oe && $past(data_pin_oe) |-> $stable(clock_pin_out) ##1 $changed(clock_pin_out))
    else $error("data not ahead of leading edge");
  a_clk_half_min: assert property (@(posedge sys_clk) disable iff (!rstn)
    $changed(clock_pin_out) |=> $stable(clock_pin_out)) else $error("clock phase too short");
endmodule // usbk_checker

bind usbk_top usbk_checker i_chk (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .data_pin_out, .data_pin_oe, .clock_pin_out, .clock_pin_oe);

// ### verification/usbk_slave_model.sv
// usbk_slave_model.sv: synchronous slave listening on the shared clock and data lines
// assumes: master makes the clock; bench tells the idle level and clears between tests
`timescale 1ns/1ps
module usbk_slave_model (
  input wire sck,
  input wire sdata,
  input wire idle_high,
  input wire clear,
  output reg [15:0] shift_reg,
  output reg [7:0] bit_cnt
);
  // sample on the trailing edge, i.e. the return to idle level
  always @(sck or posedge clear) begin
    if (clear) begin
      shift_reg = 16'h0000;
      bit_cnt = 8'h00;
    end else if (sck === idle_high) begin
      shift_reg = {sdata, shift_reg[15:1]}; // lsb first, no framing bits
      bit_cnt = bit_cnt + 8'h01;
    end
  end
endmodule // usbk_slave_model
